// ===== verilog/bct_pkg.sv
package bct_pkg;
    localparam int ADDR_W = 4;
    // Register indices on the plain register port
    localparam logic [3:0] REG_ADDR_HIGH = 4'h0;
    localparam logic [3:0] REG_ADDR_LOW  = 4'h1;
    localparam logic [3:0] REG_DATA_HIGH = 4'h2;
    localparam logic [3:0] REG_DATA_LOW  = 4'h3;
    localparam logic [3:0] REG_CTRL0     = 4'h4;
    localparam logic [3:0] REG_CTRL1     = 4'h5;
    localparam logic [3:0] REG_STATUS    = 4'h6;
    // Control register 0 fields
    localparam int CT0_MODE_HI  = 7;
    localparam int CT0_MODE_LO  = 6;
    localparam int CT0_BP1_RNG  = 1;
    localparam int CT0_BP0_RNG  = 0;
    // Control register 1 fields
    localparam int CT1_DBE      = 6;
    localparam int CT1_MASK_HI  = 5;
    localparam int CT1_MASK_LO  = 4;
    // Status register fields
    localparam int ST_TAG_ACT   = 0;
    localparam int ST_BGND      = 1;
    localparam int ST_MATCH     = 2;
    localparam int ST_SWI       = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int QUEUE_DEPTH  = 2;
    typedef enum logic [1:0] {
        BCT_MODE_OFF   = 2'b00,
        BCT_MODE_SWI2  = 2'b01,
        BCT_MODE_FULL  = 2'b10,
        BCT_MODE_DUAL  = 2'b11
    } bct_mode_e;
endpackage

// ===== verilog/bct_breakpoint_tag.sv
module bct_breakpoint_tag #(
    parameter int QDEPTH = bct_pkg::QUEUE_DEPTH
) (
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    input  wire logic        i_por_n,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_write,
    input  wire logic        i_reg_read,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic [15:0] i_cpu_data,
    input  wire logic        i_bus_valid,
    input  wire logic        i_bus_clock_fall,
    input  wire logic        i_bus_clock_rise_win,
    input  wire logic        i_fetch,
    input  wire logic        i_queue_advance,
    input  wire logic        i_tag_enable_command,
    input  wire logic        i_serial_cmd,
    input  wire logic        i_debug_exit,
    input  wire logic        i_low_byte_strobe,
    input  wire logic        i_debug_serial_pin,
    input  wire logic        i_port_e_bit3,
    output logic             o_port_e_bit3,
    output logic             o_port_e_bit3_oe,
    output logic             o_bp_match,
    output logic             o_software_interrupt,
    output logic             o_background_debug,
    output logic             o_tag_active,
    output logic             o_serial_cmd_accept,
    output logic             o_head_tag_high,
    output logic             o_head_tag_low
);
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [1:0] por_sync;
    logic       por_n;
    logic [1:0] hi_sync;
    logic [1:0] lo_sync;

    logic [7:0] break_addr_high;
    logic [7:0] break_addr_low;
    logic [7:0] break_data_high;
    logic [7:0] break_data_low;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic       tag_active;
    logic       bgnd;
    logic [1:0] tag_q [QDEPTH];
    logic       next_match;
    logic       hit0;
    logic       hit1;

    // Reset release through two flops
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Power-on reset has its own synchronised copy
    always_ff @(posedge i_clock or negedge i_por_n) begin
        if (!i_por_n) begin
            por_sync <= 2'h0;
        end else begin
            por_sync <= {por_sync[0], 1'b1};
        end
    end
    assign por_n = por_sync[1];

    // Tag pins come from the tool, so synchronise them
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_sync <= 2'h3;
            lo_sync <= 2'h3;
        end else begin
            hi_sync <= {hi_sync[0], i_debug_serial_pin};
            lo_sync <= {lo_sync[0], i_port_e_bit3};
        end
    end

    // Compare registers survive a normal reset, only power-on clears them
    always_ff @(posedge i_clock or negedge por_n) begin
        if (!por_n) begin
            break_addr_high <= bct_pkg::REG_RESET;
            break_addr_low  <= bct_pkg::REG_RESET;
            break_data_high <= bct_pkg::REG_RESET;
            break_data_low  <= bct_pkg::REG_RESET;
        end else if (i_reg_write) begin
            case (i_reg_addr)
                bct_pkg::REG_ADDR_HIGH: break_addr_high <= i_reg_wdata;
                bct_pkg::REG_ADDR_LOW:  break_addr_low  <= i_reg_wdata;
                bct_pkg::REG_DATA_HIGH: break_data_high <= i_reg_wdata;
                bct_pkg::REG_DATA_LOW:  break_data_low  <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0 <= bct_pkg::REG_RESET;
            ctrl1 <= bct_pkg::REG_RESET;
        end else if (i_reg_write) begin
            if (i_reg_addr == bct_pkg::REG_CTRL0) begin
                ctrl0 <= i_reg_wdata;
            end
            if (i_reg_addr == bct_pkg::REG_CTRL1) begin
                ctrl1 <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_read) begin
            case (i_reg_addr)
                bct_pkg::REG_ADDR_HIGH: o_reg_rdata <= break_addr_high;
                bct_pkg::REG_ADDR_LOW:  o_reg_rdata <= break_addr_low;
                bct_pkg::REG_DATA_HIGH: o_reg_rdata <= break_data_high;
                bct_pkg::REG_DATA_LOW:  o_reg_rdata <= break_data_low;
                bct_pkg::REG_CTRL0:     o_reg_rdata <= ctrl0;
                bct_pkg::REG_CTRL1:     o_reg_rdata <= ctrl1;
                bct_pkg::REG_STATUS:    o_reg_rdata <= {4'h0, o_software_interrupt,
                                                        o_bp_match, bgnd, tag_active};
                default:                o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // Breakpoint compare
    always_comb begin
        bct_pkg::bct_mode_e mode;
        mode = bct_pkg::bct_mode_e'({ctrl0[bct_pkg::CT0_MODE_HI],
                                    ctrl0[bct_pkg::CT0_MODE_LO]});
        hit0 = (i_cpu_addr[15:8] == break_addr_high)
            && (!ctrl0[bct_pkg::CT0_BP0_RNG]
                || i_cpu_addr[7:0] == break_addr_low);
        hit1 = 1'b0;
        next_match = 1'b0;
        case (mode)
            bct_pkg::BCT_MODE_OFF: begin
                next_match = 1'b0;
            end
            bct_pkg::BCT_MODE_FULL: begin
                // Data bytes only join the compare when enabled and unmasked
                next_match = hit0 && (!ctrl1[bct_pkg::CT1_DBE]
                    || ((ctrl1[bct_pkg::CT1_MASK_HI]
                         || i_cpu_data[15:8] == break_data_high)
                     && (ctrl1[bct_pkg::CT1_MASK_LO]
                         || i_cpu_data[7:0] == break_data_low)));
            end
            default: begin
                hit1 = ctrl1[bct_pkg::CT1_DBE]
                    && (i_cpu_addr[15:8] == break_data_high)
                    && (!ctrl0[bct_pkg::CT0_BP1_RNG]
                        || i_cpu_addr[7:0] == break_data_low);
                next_match = hit0 || hit1;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_bp_match           <= 1'b0;
            o_software_interrupt <= 1'b0;
        end else begin
            o_bp_match           <= i_bus_valid && next_match && !bgnd;
            o_software_interrupt <= i_bus_valid && next_match && !bgnd
                && ({ctrl0[bct_pkg::CT0_MODE_HI], ctrl0[bct_pkg::CT0_MODE_LO]}
                    == bct_pkg::BCT_MODE_SWI2);
        end
    end

    // Tagging state; no operating-mode input gates it
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            tag_active <= 1'b0;
        end else if (bgnd || (i_queue_advance && tag_q[0] != 2'h0)) begin
            // Drop tagging in the same edge that debug starts, not one later
            tag_active <= 1'b0;
        end else if (i_tag_enable_command && !tag_active) begin
            tag_active <= 1'b1;
        end
    end

    // Instruction queue of tag marks; index 0 is the head
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < QDEPTH; i++) begin
                tag_q[i] <= 2'h0;
            end
        end else if (bgnd) begin
            for (int i = 0; i < QDEPTH; i++) begin
                tag_q[i] <= 2'h0;
            end
        end else if (i_queue_advance) begin
            for (int i = 0; i < QDEPTH - 1; i++) begin
                tag_q[i] <= tag_q[i + 1];
            end
            tag_q[QDEPTH - 1] <= (tag_active && i_fetch && i_bus_clock_fall)
                ? {~hi_sync[1], ~lo_sync[1]} : 2'h0;
        end else if (tag_active && i_fetch && i_bus_clock_fall) begin
            tag_q[QDEPTH - 1] <= {~hi_sync[1], ~lo_sync[1]};
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            bgnd               <= 1'b0;
            o_background_debug <= 1'b0;
        end else begin
            if (i_debug_exit) begin
                bgnd <= 1'b0;
            end else if (i_queue_advance && tag_q[0] != 2'h0) begin
                bgnd <= 1'b1;
            end
            o_background_debug <= (bgnd && !i_debug_exit)
                || (i_queue_advance && tag_q[0] != 2'h0);
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_tag_active        <= 1'b0;
            o_serial_cmd_accept <= 1'b0;
            o_head_tag_high     <= 1'b0;
            o_head_tag_low      <= 1'b0;
        end else begin
            o_tag_active        <= tag_active;
            o_serial_cmd_accept <= i_serial_cmd && !tag_active;
            o_head_tag_high     <= tag_q[0][1];
            o_head_tag_low      <= tag_q[0][0];
        end
    end

    // Strobe owns the shared pin around the rising edge and whenever tagging is off; tool must stay off then
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_port_e_bit3    <= 1'b0;
            o_port_e_bit3_oe <= 1'b0;
        end else begin
            o_port_e_bit3    <= i_low_byte_strobe;
            o_port_e_bit3_oe <= i_bus_clock_rise_win || !tag_active;
        end
    end
endmodule // bct_breakpoint_tag

// ===== tb/bct_bt_properties.sv
module bct_bt_props (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_por_n,
    input wire logic i_bus_valid,
    input wire logic i_bus_clock_rise_win,
    input wire logic i_tag_enable_command,
    input wire logic i_debug_exit,
    input wire logic i_low_byte_strobe,
    input wire logic o_port_e_bit3,
    input wire logic o_port_e_bit3_oe,
    input wire logic o_bp_match,
    input wire logic o_software_interrupt,
    input wire logic o_background_debug,
    input wire logic o_tag_active,
    input wire logic o_serial_cmd_accept,
    input wire logic o_head_tag_high,
    input wire logic o_head_tag_low
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n || !i_por_n);
    AST_MATCH_CAUSE: assert property (o_bp_match |-> $past(i_bus_valid))
        else $error("match without a bus cycle");
    AST_SWI_CAUSE: assert property (o_software_interrupt |-> $past(i_bus_valid))
        else $error("software interrupt without a bus cycle");
    AST_TAG_START: assert property (i_tag_enable_command && !o_background_debug |-> ##[1:2] o_tag_active)
        else $error("tagging did not start");
    AST_TAG_CAUSE: assert property ($rose(o_tag_active) |-> $past(i_tag_enable_command) || $past(i_tag_enable_command, 2))
        else $error("tagging started without command");
    AST_NO_CMD_TAG: assert property (!(o_tag_active && o_serial_cmd_accept))
        else $error("serial command taken while tagging");
    AST_TAG_OFF: assert property (o_background_debug |-> ##[0:1] !o_tag_active)
        else $error("tagging left on in debug");
    AST_HEAD_BGND: assert property ($rose(o_head_tag_high || o_head_tag_low) |-> ##[0:2] o_background_debug)
        else $error("tagged head did not enter debug");
    AST_BGND_HOLD: assert property (o_background_debug && !i_debug_exit |=> o_background_debug)
        else $error("debug left without exit");
    AST_STROBE_OUT: assert property (o_port_e_bit3_oe && o_tag_active |-> $past(i_bus_clock_rise_win) && o_port_e_bit3 == $past(i_low_byte_strobe))
        else $error("strobe driven outside window");
    COV_TAG: cover property ($rose(o_tag_active));
    COV_BGND: cover property ($rose(o_background_debug));
    COV_MATCH: cover property (o_bp_match);
endmodule // bct_bt_props

bind bct_breakpoint_tag bct_bt_props bct_bt_props_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_por_n(i_por_n), .i_bus_valid(i_bus_valid), .i_bus_clock_rise_win(i_bus_clock_rise_win),
    .i_tag_enable_command(i_tag_enable_command), .i_debug_exit(i_debug_exit),
    .i_low_byte_strobe(i_low_byte_strobe), .o_port_e_bit3(o_port_e_bit3),
    .o_port_e_bit3_oe(o_port_e_bit3_oe), .o_bp_match(o_bp_match),
    .o_software_interrupt(o_software_interrupt), .o_background_debug(o_background_debug),
    .o_tag_active(o_tag_active), .o_serial_cmd_accept(o_serial_cmd_accept),
    .o_head_tag_high(o_head_tag_high), .o_head_tag_low(o_head_tag_low));

// ===== tb/bct_dev_tool.sv
module bct_dev_tool (
    input  wire logic i_drive,
    input  wire logic i_tag_high_n,
    input  wire logic i_tag_low_n,
    input  wire logic i_rise_win,
    input  wire logic i_strobe_oe,
    output logic      o_high_pin,
    output logic      o_low_pin,
    output logic      o_low_oe
);
    // Debug pin has a passive pull-up, so a released pin reads high
    assign o_high_pin = i_drive ? i_tag_high_n : 1'b1;
    // Back off around the rising edge so the strobe never fights the tool
    assign o_low_oe = i_drive && !i_rise_win && !i_strobe_oe;
    assign o_low_pin = i_tag_low_n;
endmodule // bct_dev_tool

// ===== tb/bct_breakpoint_tag_tb.sv
module bct_breakpoint_tag_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [51:0] CASES [14] = '{
        52'h80_00_12ff_0000_1, 52'h81_00_12ff_0000_0, 52'h81_00_1234_0000_1,
        52'h01_00_1234_0000_0, 52'h81_40_1234_5678_1, 52'h81_40_1234_5600_0,
        52'h81_50_1234_5600_1, 52'h81_60_1234_0078_1, 52'hc0_40_56ff_0000_1,
        52'hc0_00_56ff_0000_0, 52'hc2_40_56ff_0000_0, 52'hc2_40_5678_0000_1,
        52'h41_00_1234_0000_1, 52'h41_40_5678_0000_1};
    logic        i_clock = 1'b0, i_arst_n = 1'b0, i_por_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, rdata;
    logic        reg_write = 1'b0, reg_read = 1'b0, bus_valid = 1'b0, fetch = 1'b0;
    logic        adv = 1'b0, tag_cmd = 1'b0, ser_cmd = 1'b0, dbg_exit = 1'b0;
    logic [15:0] cpu_addr = 16'h0000, cpu_data = 16'h0000;
    logic [2:0]  cnt = 3'h0;
    logic        drive = 1'b0, thi_n = 1'b1, tlo_n = 1'b1, hh, hl;
    logic        pe3_out, pe3_oe, match, software_interrupt, bgnd, tag_act, accept, head_hi, head_lo;
    logic        hi_pin, lo_pin, lo_oe;
    wire         pe3_wire = pe3_oe ? pe3_out : (lo_oe ? lo_pin : 1'b1);
    int          fail_count = 0, compares = 0, cyc = 0;

    initial begin
        forever #5 i_clock = ~i_clock;
    end
    // Bus clock modelled as 8 system cycles: rise window at 0, fall point at 4
    always @(posedge i_clock) begin
        cnt <= cnt + 3'h1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end
    bct_breakpoint_tag #(.QDEPTH(2)) bct_breakpoint_tag_inst (.i_clock(i_clock),
        .i_arst_n(i_arst_n), .i_por_n(i_por_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(rdata),
        .i_cpu_addr(cpu_addr), .i_cpu_data(cpu_data), .i_bus_valid(bus_valid),
        .i_bus_clock_fall(cnt == 3'h4), .i_bus_clock_rise_win(cnt == 3'h0), .i_fetch(fetch),
        .i_queue_advance(adv), .i_tag_enable_command(tag_cmd), .i_serial_cmd(ser_cmd),
        .i_debug_exit(dbg_exit), .i_low_byte_strobe(cnt[1]), .i_debug_serial_pin(hi_pin),
        .i_port_e_bit3(pe3_wire), .o_port_e_bit3(pe3_out), .o_port_e_bit3_oe(pe3_oe),
        .o_bp_match(match), .o_software_interrupt(software_interrupt), .o_background_debug(bgnd),
        .o_tag_active(tag_act), .o_serial_cmd_accept(accept), .o_head_tag_high(head_hi),
        .o_head_tag_low(head_lo));
    bct_dev_tool bct_dev_tool_inst (.i_drive(drive), .i_tag_high_n(thi_n), .i_tag_low_n(tlo_n),
        .i_rise_win(cnt == 3'h0), .i_strobe_oe(pe3_oe), .o_high_pin(hi_pin),
        .o_low_pin(lo_pin), .o_low_oe(lo_oe));

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge i_clock);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge i_clock);
        reg_read <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Selector rather than a ref argument keeps every strobe a module-level NBA
    task pulse(input int w);
        @(posedge i_clock);
        case (w)
            0: dbg_exit <= 1'b1;
            1: tag_cmd <= 1'b1;
            2: ser_cmd <= 1'b1;
            default: adv <= 1'b1;
        endcase
        @(posedge i_clock);
        {dbg_exit, tag_cmd, ser_cmd, adv} <= 4'h0;
    endtask
    task stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_clock);
        i_arst_n <= 1'b1;
        i_por_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 4; i++) wr(i[3:0], 8'h12 + 8'h22 * i[7:0]);
        @(posedge i_clock);
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 4; i++) rd(i[3:0], 8'h12 + 8'h22 * i[7:0]);
        rd(4'hf, 8'h00);
        $display("test registers done");
        foreach (CASES[i]) begin
            wr(bct_pkg::REG_CTRL0, CASES[i][51:44]);
            wr(bct_pkg::REG_CTRL1, CASES[i][43:36]);
            @(posedge i_clock);
            cpu_addr <= CASES[i][35:20];
            cpu_data <= CASES[i][19:4];
            bus_valid <= 1'b1;
            @(posedge i_clock);
            bus_valid <= 1'b0;
            #1 chk({7'h0, CASES[i][51:50] == 2'b01 ? software_interrupt : match}, {7'h0, CASES[i][0]});
            pulse(0);
        end
        $display("test breakpoints done");
        wr(bct_pkg::REG_CTRL0, 8'h00);
        pulse(2);
        #1 chk({7'h0, accept}, 8'h01);
        for (int k = 3; k >= 0; k--) begin
            pulse(0);
            pulse(1);
            repeat (2) @(posedge i_clock);
            #1 chk({7'h0, tag_act}, 8'h01);
            pulse(2);
            #1 chk({7'h0, accept}, 8'h00);
            @(posedge i_clock);
            drive <= 1'b1;
            thi_n <= k[1];
            tlo_n <= k[0];
            repeat (8) @(posedge i_clock);
            while (cnt !== 3'h3) @(posedge i_clock);
            fetch <= 1'b1;
            cpu_data <= 16'habcd;
            @(posedge i_clock);
            fetch <= 1'b0;
            repeat (4) @(posedge i_clock);
            drive <= 1'b0;
            hh = 1'b0;
            hl = 1'b0;
            repeat (3) begin
                pulse(3);
                #1 hh = hh | head_hi;
                hl = hl | head_lo;
            end
            repeat (2) @(posedge i_clock);
            #1 chk({6'h0, hh, hl}, {6'h0, ~k[1:0]});
            chk({7'h0, bgnd}, {7'h0, k != 3});
            chk({7'h0, tag_act}, {7'h0, k == 3});
        end
        $display("test tagging done");
        pulse(0);
        @(posedge i_clock);
        i_por_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        i_por_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
        $display("test power-on done");
        stop_test();
    end
endmodule // bct_breakpoint_tag_tb
